/* File: bsd_pkg.sv */
// package for the battery short diagnostic control block
package bsd_pkg;
  localparam logic [7:0] ADDR_CH_ONE_CTRL    = 8'h5D;
  localparam logic [7:0] ADDR_CH_TWO_CTRL    = 8'h5E;
  localparam logic [7:0] ADDR_STATUS         = 8'h5F;
  localparam logic [7:0] ADDR_SUB_MAP        = 8'h0E;
  localparam int         POWERDOWN_BIT       = 6;
  localparam int         THRESH_LSB          = 2;
  localparam int         THRESH_MSB          = 4;
  localparam int         SUB_MAP_LSB         = 5;
  localparam int         SUB_MAP_MSB         = 6;
  localparam logic [1:0] SUB_MAP_USER        = 2'h0;
  localparam logic       POWERDOWN_RESET     = 1'h1;
  localparam logic [2:0] THRESH_RESET        = 3'h3;
  localparam logic [1:0] SUB_MAP_RESET       = 2'h0;
  localparam int         NUM_CHANNELS        = 2;

  typedef struct packed {
    logic       powerDown;
    logic [2:0] threshold;
  } bsd_chan_s;

  typedef struct packed {
    bsd_chan_s [NUM_CHANNELS-1:0] chan;
    logic [1:0]                   subMap;
    logic [NUM_CHANNELS-1:0]      stbLatched;
    logic [7:0]                   readData;
  } bsd_state_s;
endpackage : bsd_pkg

/* File: bsd_ctrl.sv */
// battery short diagnostic control, status latch and interrupt request
//
// Overview of operation
// - Register sense_channel_one_control bit 6 powers channel one down when 1 and up when 0, resetting to 1.
// - Register sense_channel_one_control bits 4:2 hold channel one's threshold code (75 mV plus 150 mV per step), resetting to 011.
// - A channel one comparator trip above its threshold raises a battery short interrupt.
// - Register sense_channel_two_control bit 6 powers channel two down when 1 and up when 0, resetting to 1.
// - Register sense_channel_two_control bits 4:2 hold channel two's threshold code with the same encoding, resetting to 011.
// - A channel two comparator trip above its threshold raises a battery short interrupt.
// - A battery short event shows as the active low interrupt request pin.
// - A readable status register tells which channel tripped.
`timescale 1ns/10ps
module bsd_ctrl (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic       sensePinOneTrip,
  input  wire logic       sensePinTwoTrip,
  output logic            senseOnePowerdown,
  output logic            senseTwoPowerdown,
  output logic      [2:0] senseOneThreshold,
  output logic      [2:0] senseTwoThreshold,
  output logic            batteryShortEvent,
  output logic            interruptRequestOut_n
);
  bsd_pkg::bsd_state_s state_r;
  bsd_pkg::bsd_state_s state_nxt;
  logic [bsd_pkg::NUM_CHANNELS-1:0] trip;
  logic [bsd_pkg::NUM_CHANNELS-1:0] tripGated;
  logic                             userMap;

  assign trip    = {sensePinTwoTrip, sensePinOneTrip};
  assign userMap = (state_r.subMap == bsd_pkg::SUB_MAP_USER);

  genvar g;
  generate
    for (g = 0; g < bsd_pkg::NUM_CHANNELS; g++) begin : gChan
      // powered down comparators are masked
      assign tripGated[g] = trip[g] & ~state_r.chan[g].powerDown;
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;
    if (regWrite && regAddr == bsd_pkg::ADDR_SUB_MAP) begin
      state_nxt.subMap = regWdata[bsd_pkg::SUB_MAP_MSB:bsd_pkg::SUB_MAP_LSB];
    end
    if (regWrite && userMap && regAddr == bsd_pkg::ADDR_CH_ONE_CTRL) begin
      state_nxt.chan[0].powerDown = regWdata[bsd_pkg::POWERDOWN_BIT];
      state_nxt.chan[0].threshold = regWdata[bsd_pkg::THRESH_MSB:bsd_pkg::THRESH_LSB];
    end
    if (regWrite && userMap && regAddr == bsd_pkg::ADDR_CH_TWO_CTRL) begin
      state_nxt.chan[1].powerDown = regWdata[bsd_pkg::POWERDOWN_BIT];
      state_nxt.chan[1].threshold = regWdata[bsd_pkg::THRESH_MSB:bsd_pkg::THRESH_LSB];
    end
    // write one to clear; a new trip in the same cycle wins
    if (regWrite && userMap && regAddr == bsd_pkg::ADDR_STATUS) begin
      state_nxt.stbLatched = state_r.stbLatched & ~regWdata[bsd_pkg::NUM_CHANNELS-1:0];
    end
    state_nxt.stbLatched = state_nxt.stbLatched | tripGated;
    state_nxt.readData = 8'h00;
    if (regRead) begin
      if (regAddr == bsd_pkg::ADDR_SUB_MAP) begin
        state_nxt.readData[bsd_pkg::SUB_MAP_MSB:bsd_pkg::SUB_MAP_LSB] = state_r.subMap;
      end else if (userMap && regAddr == bsd_pkg::ADDR_CH_ONE_CTRL) begin
        state_nxt.readData[bsd_pkg::POWERDOWN_BIT] = state_r.chan[0].powerDown;
        state_nxt.readData[bsd_pkg::THRESH_MSB:bsd_pkg::THRESH_LSB] = state_r.chan[0].threshold;
      end else if (userMap && regAddr == bsd_pkg::ADDR_CH_TWO_CTRL) begin
        state_nxt.readData[bsd_pkg::POWERDOWN_BIT] = state_r.chan[1].powerDown;
        state_nxt.readData[bsd_pkg::THRESH_MSB:bsd_pkg::THRESH_LSB] = state_r.chan[1].threshold;
      end else if (userMap && regAddr == bsd_pkg::ADDR_STATUS) begin
        state_nxt.readData[bsd_pkg::NUM_CHANNELS-1:0] = state_r.stbLatched;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r.chan[0].powerDown <= bsd_pkg::POWERDOWN_RESET;
      state_r.chan[0].threshold <= bsd_pkg::THRESH_RESET;
      state_r.chan[1].powerDown <= bsd_pkg::POWERDOWN_RESET;
      state_r.chan[1].threshold <= bsd_pkg::THRESH_RESET;
      state_r.subMap            <= bsd_pkg::SUB_MAP_RESET;
      state_r.stbLatched        <= 2'h0;
      state_r.readData          <= 8'h00;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign regRdata              = state_r.readData;
  assign senseOnePowerdown     = state_r.chan[0].powerDown;
  assign senseTwoPowerdown     = state_r.chan[1].powerDown;
  assign senseOneThreshold     = state_r.chan[0].threshold;
  assign senseTwoThreshold     = state_r.chan[1].threshold;
  assign batteryShortEvent     = |state_r.stbLatched;
  assign interruptRequestOut_n = ~(|state_r.stbLatched);
endmodule : bsd_ctrl

/* File: bsd_ctrl_props.sv */
// assertions on the battery short control block ports
`timescale 1ns/10ps
module bsd_ctrl_props (
  input wire logic sys_clk, rstn, regWrite, regRead, sensePinOneTrip, sensePinTwoTrip,
  input wire logic senseOnePowerdown, senseTwoPowerdown, batteryShortEvent, interruptRequestOut_n,
  input wire logic [7:0] regAddr, regWdata, regRdata,
  input wire logic [2:0] senseOneThreshold);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [1:0] subMap_r;
  always_ff @(posedge sys_clk or negedge rstn) subMap_r <= !rstn ? 2'h0 : (regWrite && regAddr == 8'h0E) ? regWdata[6:5] : subMap_r;
  irq_level_a: assert property (interruptRequestOut_n == !batteryShortEvent) else $error("irq level");
  one_trip_a: assert property (sensePinOneTrip && !senseOnePowerdown |=> batteryShortEvent) else $error("trip one");
  two_trip_a: assert property (sensePinTwoTrip && !senseTwoPowerdown |=> batteryShortEvent) else $error("trip two");
  off_quiet_a: assert property (!batteryShortEvent && !(sensePinOneTrip && !senseOnePowerdown) &&
    !(sensePinTwoTrip && !senseTwoPowerdown) |=> !batteryShortEvent) else $error("event unasked");
  event_held_a: assert property (batteryShortEvent && !regWrite |=> batteryShortEvent) else $error("event dropped");
  one_ctrl_a: assert property (regWrite && regAddr == 8'h5D && subMap_r == 2'h0 |=>
    senseOnePowerdown == $past(regWdata[6]) && senseOneThreshold == $past(regWdata[4:2])) else $error("ctrl one");
  two_ctrl_a: assert property (regWrite && regAddr == 8'h5E && subMap_r == 2'h0 |=>
    senseTwoPowerdown == $past(regWdata[6])) else $error("ctrl two");
  status_read_a: assert property (regRead && regAddr == 8'h5F && subMap_r == 2'h0 |=>
    (regRdata[1:0] != 2'h0) == $past(batteryShortEvent)) else $error("status read");
  cover property (batteryShortEvent && sensePinTwoTrip);
  cover property (regRead && regAddr == 8'h5F && batteryShortEvent);
  cover property (regWrite && subMap_r != 2'h0);
endmodule : bsd_ctrl_props
bind bsd_ctrl bsd_ctrl_props chk_u (.*);

/* File: bsd_comparator_model.sv */
// behavioural comparator behind one sense pin, voltage in mV
`timescale 1ns/10ps
module bsd_comparator_model (input wire logic [11:0] senseMv, input wire logic powerDown,
  input wire logic [2:0] threshold, output logic trip);
  assign trip = !powerDown && (senseMv > 12'h04B + 12'h096 * threshold);
endmodule : bsd_comparator_model

/* File: tb_battery_short_diag_control.sv */
// self-checking bench for the battery short control block
`timescale 1ns/10ps
module tb_battery_short_diag_control;
  logic sys_clk = 0, rstn = 0, regWrite = 0, regRead = 0, t1, t2, pd1, pd2, ev, irqN;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rd = 8'h00;
  logic [2:0] th1, th2;
  logic [11:0] mv1 = 12'h000, mv2 = 12'h000;
  int n_errors = 0, n_compared = 0;
  bsd_ctrl dut_u (.sys_clk(sys_clk), .rstn(rstn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .sensePinOneTrip(t1), .sensePinTwoTrip(t2), .senseOnePowerdown(pd1),
    .senseTwoPowerdown(pd2), .senseOneThreshold(th1), .senseTwoThreshold(th2), .batteryShortEvent(ev),
    .interruptRequestOut_n(irqN));
  bsd_comparator_model cmp1_u (.senseMv(mv1), .powerDown(pd1), .threshold(th1), .trip(t1));
  bsd_comparator_model cmp2_u (.senseMv(mv2), .powerDown(pd2), .threshold(th2), .trip(t2));
  initial forever #20 sys_clk = ~sys_clk;
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin n_errors++; $display("BAD %s exp %h got %h", what, exp, got); end
  endtask : chk
  // one strobe edge; read data stands for the one cycle after it and is captured there
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk) #1 {regWrite, regRead, regAddr, regWdata} = {w, !w, a, d};
    @(posedge sys_clk) #1 {regWrite, regRead} = 2'h0;
    rd = regRdata;
    @(posedge sys_clk) #1;
  endtask : acc
  task automatic results();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 rstn = 1;
    chk("pd", 8'h03, {pd2, pd1});
    chk("thr", 8'h1B, {th2, th1});
    mv1 = 12'h4B0;
    acc(1, 8'h0E, 8'h40);
    acc(1, 8'h5D, 8'h00);
    chk("off map", 8'h03, {ev, irqN, pd1});
    acc(1, 8'h0E, 8'h00);
    acc(0, 8'h30, 8'h00); chk("unmapped", 8'h00, rd);
    mv1 = 12'h000;
    $display("reset and refusal test done");
    for (int c = 0; c < 8; c++) begin
      acc(1, 8'h5D, 8'(c << 2)); mv1 = 12'h04B + 12'(12'h096 * c);
      acc(0, 8'h5F, 8'h00); chk("at level", 8'h00, rd);
      mv1 = mv1 + 12'h001;
      acc(0, 8'h5F, 8'h00); chk("status", 8'h01, rd);
      chk("irq", 8'h02, {ev, irqN});
      mv1 = 12'h000;
      acc(1, 8'h5F, 8'h01); chk("clear", 8'h01, {ev, irqN});
    end
    acc(1, 8'h5E, 8'h1C); mv2 = 12'h466; chk("thr two", 8'h07, th2);
    acc(0, 8'h5F, 8'h00); chk("status two", 8'h02, rd);
    mv2 = 12'h000; acc(1, 8'h5F, 8'h02); chk("clear two", 8'h01, {ev, irqN});
    $display("threshold and status test done");
    results();
  end
endmodule : tb_battery_short_diag_control
